// ### common/rra_pkg.sv
// Shared constants and types for the readout result averager
package rra_pkg;
  localparam int DATA_W  = 24;
  localparam int STATE_W = 4;
  localparam int LEN_W   = 19;
  localparam int AVG_W   = 17;

  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_LEN    = 8'h04;
  localparam logic [7:0] ADR_AVG    = 8'h08;
  localparam logic [7:0] ADR_ACQ_LO = 8'h0c;
  localparam logic [7:0] ADR_STAT   = 8'h10;
  localparam logic [7:0] ADR_IRQ    = 8'h14;
  localparam logic [7:0] ADR_MASK   = 8'h18;
  localparam logic [7:0] ADR_RIDX   = 8'h1c;
  localparam logic [7:0] ADR_RDATA  = 8'h20;
  localparam logic [7:0] ADR_ACQ_HI = 8'h24;

  localparam int CTRL_RUN  = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_SRC  = 2;
  localparam int ST_RUN    = 0;
  localparam int ST_DIV    = 1;
  localparam int ST_FAIL   = 2;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_TMO   = 1;
  localparam int IRQ_OVR   = 2;
  localparam int IRQ_W     = 3;

  localparam logic [LEN_W:0] LEN_RST = 20'h00001;
  localparam logic [AVG_W:0] AVG_RST = 18'h00001;

  localparam int CLK_NS      = 100;
  localparam int MIN_GAP_NS  = 440;
  localparam int MIN_GAP_CYC = (MIN_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMO_MS      = 100;
  localparam int TMO_CYC     = TMO_MS * 1000000 / CLK_NS;

  typedef enum logic [2:0] {
    RRA_IDLE = 3'b001,
    RRA_RUN  = 3'b010,
    RRA_FAIL = 3'b100
  } rra_state_t;
endpackage

// ### core/rra_divider.sv
// Sequential signed-by-unsigned restoring divider for point averages
`timescale 1ns/100ps
module rra_divider #(
  parameter int N_W = 41,
  parameter int D_W = 18
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_start,
  input  wire logic signed [N_W-1:0] i_dividend,
  input  wire logic        [D_W-1:0] i_divisor,
  output logic signed      [N_W-1:0] o_quot,
  output logic                       o_busy
);
  localparam int C_W = $clog2(N_W + 1);

  logic [N_W-1:0] quo;
  logic [D_W-1:0] rem;
  logic [D_W-1:0] dv;
  logic [C_W-1:0] cnt;
  logic           neg;
  logic [D_W:0]   shifted;
  logic [D_W:0]   diff;
  logic           fits;
  logic [N_W-1:0] next_quo;

  always_comb begin
    shifted  = {rem, quo[N_W-1]};
    diff     = shifted - {1'b0, dv};
    fits     = shifted >= {1'b0, dv};
    next_quo = {quo[N_W-2:0], fits};
  end

  // Works on the magnitude so the most negative sum still divides correctly
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quo    <= '0;
      rem    <= '0;
      dv     <= '0;
      cnt    <= '0;
      neg    <= 1'b0;
      o_busy <= 1'b0;
      o_quot <= '0;
    end else if (i_start) begin
      quo    <= i_dividend[N_W-1] ? N_W'(-i_dividend) : i_dividend;
      rem    <= '0;
      dv     <= i_divisor;
      neg    <= i_dividend[N_W-1];
      cnt    <= C_W'(N_W);
      o_busy <= 1'b1;
    end else if (o_busy) begin
      quo <= next_quo;
      rem <= fits ? diff[D_W-1:0] : shifted[D_W-1:0];
      cnt <= cnt - 1'b1;
      if (cnt == C_W'(1)) begin
        o_busy <= 1'b0;
        o_quot <= neg ? N_W'(-next_quo) : next_quo;
      end
    end
  end
endmodule

// ### core/rra_logger.sv
// Readout result logger: hardware averaging of readout results, APB slave
//
// Notes on behaviour
// - Vector length accepted from one to 2^19 points, step one.
// - Each vector entry holds one averaged value of the selected source.
// - Averaging count accepted from one to 2^17, step one.
// - Progress counter gives index of the next result to record.
// - Cyclic mode: point k averages results k, M+k, 2M+k and onward.
// - Sequential mode: each point averages N consecutive results.
// - Source selector picks integration values or thresholded state outputs.
// - Logger stops itself when results equal length times averages, or on timeout.
// - Too few results before completion raise a timeout error.
// - Run starts acquisition clearing progress; stop halts it early.
`timescale 1ns/100ps
module rra_logger #(
  parameter int DATA_W  = rra_pkg::DATA_W,
  parameter int STATE_W = rra_pkg::STATE_W,
  parameter int LEN_W   = rra_pkg::LEN_W,
  parameter int AVG_W   = rra_pkg::AVG_W,
  parameter int TMO_CYC = rra_pkg::TMO_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire logic               i_int_valid,
  input  wire logic [DATA_W-1:0]  i_int_data,
  input  wire logic               i_thr_valid,
  input  wire logic [STATE_W-1:0] i_thr_data,
  output logic                    o_irq,
  output logic                    o_running
);
  // Sum of 2^AVG_W full-scale samples needs AVG_W extra bits
  localparam int ACC_W = DATA_W + AVG_W;
  localparam int CNT_W = LEN_W + AVG_W + 2;
  localparam int GAP_W = 4;

  rra_pkg::rra_state_t state;
  logic                      mode;
  logic                      src;
  logic [LEN_W:0]            len;
  logic [AVG_W:0]            avg;
  logic [LEN_W-1:0]          pt;
  logic [AVG_W-1:0]          rep;
  logic [CNT_W-1:0]          acq;
  logic [CNT_W-1:0]          total;
  logic [31:0]               tmo_cnt;
  logic [GAP_W-1:0]          gap;
  logic [rra_pkg::IRQ_W-1:0] irq_stat;
  logic [rra_pkg::IRQ_W-1:0] irq_mask;
  logic [LEN_W-1:0]          res_idx;
  logic                      div_start;
  logic signed [ACC_W-1:0]   mem [0:(2**LEN_W)-1];
  logic signed [ACC_W-1:0]   quot;
  logic                      div_busy;

  logic                      acc_ph;
  logic                      wr;
  logic                      start;
  logic                      stop;
  logic                      smp_v;
  logic signed [ACC_W-1:0]   smp_x;
  logic                      take;
  logic                      pt_last;
  logic                      rep_last;
  logic                      all_done;
  logic                      tmo_hit;
  logic                      too_fast;
  logic [rra_pkg::IRQ_W-1:0] irq_set;
  logic [31:0]               rd_mux;
  logic                      hit;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    acc_ph = i_psel & i_penable & o_pready;
    wr     = acc_ph & i_pwrite;
    start  = wr & (i_paddr == rra_pkg::ADR_CTRL) & i_pwdata[rra_pkg::CTRL_RUN];
    stop   = wr & (i_paddr == rra_pkg::ADR_CTRL) & ~i_pwdata[rra_pkg::CTRL_RUN];
  end

  always_comb begin
    smp_v = src ? i_thr_valid : i_int_valid;
    if (src)
      smp_x = ACC_W'(i_thr_data);
    else
      smp_x = {{AVG_W{i_int_data[DATA_W-1]}}, i_int_data};
  end

  always_comb begin
    take     = (state == rra_pkg::RRA_RUN) & smp_v;
    pt_last  = ({1'b0, pt} == len - 1'b1);
    rep_last = ({1'b0, rep} == avg - 1'b1);
    all_done = (acq + 1'b1 == total);
    tmo_hit  = (tmo_cnt == 32'(TMO_CYC - 1));
    too_fast = (gap < GAP_W'(rra_pkg::MIN_GAP_CYC));
  end

  ////////////////////////////////////////////////////////////////////////
  // run and stop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= rra_pkg::RRA_IDLE;
    end else begin
      case (state)
        rra_pkg::RRA_IDLE: begin
          if (start)
            state <= rra_pkg::RRA_RUN;
        end
        rra_pkg::RRA_RUN: begin
          if (stop)
            state <= rra_pkg::RRA_IDLE;
          // A start while running only restarts the counters
          else if (start)
            state <= rra_pkg::RRA_RUN;
          else if (take && all_done)
            state <= rra_pkg::RRA_IDLE;
          else if (!take && tmo_hit)
            state <= rra_pkg::RRA_FAIL;
        end
        rra_pkg::RRA_FAIL: begin
          if (start)
            state <= rra_pkg::RRA_RUN;
          else if (stop)
            state <= rra_pkg::RRA_IDLE;
        end
        default: state <= rra_pkg::RRA_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pt    <= '0;
      rep   <= '0;
      acq   <= '0;
      total <= '0;
    end else if (start) begin
      pt    <= '0;
      rep   <= '0;
      acq   <= '0;
      total <= CNT_W'(len) * CNT_W'(avg);
    end else if (take) begin
      acq <= acq + 1'b1;
      if (!mode) begin
        pt <= pt_last ? '0 : pt + 1'b1;
        if (pt_last)
          rep <= rep + 1'b1;
      end else begin
        rep <= rep_last ? '0 : rep + 1'b1;
        if (rep_last)
          pt <= pt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (take)
      mem[pt] <= (rep == '0) ? smp_x : mem[pt] + smp_x;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      tmo_cnt <= '0;
    else if (start || take || state != rra_pkg::RRA_RUN)
      tmo_cnt <= '0;
    else
      tmo_cnt <= tmo_cnt + 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      gap <= '1;
    else if (start)
      gap <= '1;
    else if (take)
      gap <= GAP_W'(1);
    else if (gap != '1)
      gap <= gap + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode and source are frozen while running so a run never mixes them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= 1'b0;
      src  <= 1'b0;
    end else if (wr && i_paddr == rra_pkg::ADR_CTRL && state != rra_pkg::RRA_RUN) begin
      mode <= i_pwdata[rra_pkg::CTRL_MODE];
      src  <= i_pwdata[rra_pkg::CTRL_SRC];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      len <= rra_pkg::LEN_RST;
    else if (wr && i_paddr == rra_pkg::ADR_LEN && state != rra_pkg::RRA_RUN)
      len <= (i_pwdata[LEN_W:0] == '0 || i_pwdata[LEN_W:0] > (LEN_W+1)'(2**LEN_W))
             ? rra_pkg::LEN_RST : i_pwdata[LEN_W:0];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      avg <= rra_pkg::AVG_RST;
    else if (wr && i_paddr == rra_pkg::ADR_AVG && state != rra_pkg::RRA_RUN)
      avg <= (i_pwdata[AVG_W:0] == '0 || i_pwdata[AVG_W:0] > (AVG_W+1)'(2**AVG_W))
             ? rra_pkg::AVG_RST : i_pwdata[AVG_W:0];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      res_idx   <= '0;
      div_start <= 1'b0;
    end else begin
      div_start <= wr && i_paddr == rra_pkg::ADR_RIDX;
      if (wr && i_paddr == rra_pkg::ADR_RIDX)
        res_idx <= i_pwdata[LEN_W-1:0];
    end
  end

  // mean is sum over averaging count
  rra_divider #(
    .N_W (ACC_W),
    .D_W (AVG_W + 1)
  ) u_div (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_start    (div_start),
    .i_dividend (mem[res_idx]),
    .i_divisor  (avg),
    .o_quot     (quot),
    .o_busy     (div_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    irq_set                    = '0;
    irq_set[rra_pkg::IRQ_DONE] = take & all_done & ~stop & ~start;
    irq_set[rra_pkg::IRQ_TMO]  = (state == rra_pkg::RRA_RUN) & ~take & tmo_hit & ~stop & ~start;
    irq_set[rra_pkg::IRQ_OVR]  = take & too_fast;
  end

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat <= '0;
      irq_mask <= '0;
      o_irq    <= 1'b0;
    end else begin
      if (wr && i_paddr == rra_pkg::ADR_IRQ)
        irq_stat <= (irq_stat & ~i_pwdata[rra_pkg::IRQ_W-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      if (wr && i_paddr == rra_pkg::ADR_MASK)
        irq_mask <= i_pwdata[rra_pkg::IRQ_W-1:0];
      o_irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    case (i_paddr)
      rra_pkg::ADR_CTRL: begin
        rd_mux[rra_pkg::CTRL_RUN]  = (state == rra_pkg::RRA_RUN);
        rd_mux[rra_pkg::CTRL_MODE] = mode;
        rd_mux[rra_pkg::CTRL_SRC]  = src;
      end
      rra_pkg::ADR_LEN:    rd_mux = 32'(len);
      rra_pkg::ADR_AVG:    rd_mux = 32'(avg);
      rra_pkg::ADR_ACQ_LO: rd_mux = acq[31:0];
      rra_pkg::ADR_ACQ_HI: rd_mux = 32'(acq[CNT_W-1:32]);
      rra_pkg::ADR_STAT: begin
        rd_mux[rra_pkg::ST_RUN]  = (state == rra_pkg::RRA_RUN);
        rd_mux[rra_pkg::ST_DIV]  = div_busy | div_start;
        rd_mux[rra_pkg::ST_FAIL] = (state == rra_pkg::RRA_FAIL);
      end
      rra_pkg::ADR_IRQ:    rd_mux = 32'(irq_stat);
      rra_pkg::ADR_MASK:   rd_mux = 32'(irq_mask);
      rra_pkg::ADR_RIDX:   rd_mux = 32'(res_idx);
      rra_pkg::ADR_RDATA:  rd_mux = {{(32-DATA_W){quot[DATA_W-1]}}, quot[DATA_W-1:0]};
      default:             hit = 1'b0;
    endcase
  end

  // One wait state: the answer is registered in the first access cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
      o_running <= 1'b0;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_prdata  <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_mux : '0;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
      o_running <= (state == rra_pkg::RRA_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_start_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    start |=> acq == '0 && state == rra_pkg::RRA_RUN) else $error("start did not clear progress");
  a_stop_halts: assert property (@(posedge i_clk) disable iff (i_rst)
    stop && state == rra_pkg::RRA_RUN |=> state == rra_pkg::RRA_IDLE ##1 !o_running)
    else $error("stop did not halt");
  a_done_total: assert property (@(posedge i_clk) disable iff (i_rst)
    take && all_done && !stop && !start |=> state == rra_pkg::RRA_IDLE && irq_stat[rra_pkg::IRQ_DONE]
    && acq == total) else $error("no stop at total");
  a_no_early_end: assert property (@(posedge i_clk) disable iff (i_rst)
    state == rra_pkg::RRA_RUN && !stop && !(take && all_done) && !tmo_hit
    |=> state == rra_pkg::RRA_RUN) else $error("run ended early");
  a_progress_step: assert property (@(posedge i_clk) disable iff (i_rst)
    take && !start |=> acq == $past(acq) + 1'b1) else $error("progress not stepped");
  a_cyclic_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    take && !mode && pt_last && !start |=> pt == '0 && rep == $past(rep) + 1'b1) else $error("cyclic wrap wrong");
  a_seq_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    take && mode && rep_last && !start |=> rep == '0 && pt == $past(pt) + 1'b1) else $error("sequential wrap wrong");
  a_first_store: assert property (@(posedge i_clk) disable iff (i_rst)
    take && rep == '0 |=> mem[$past(pt)] == $past(smp_x)) else $error("first result not stored");
  a_thr_source: assert property (@(posedge i_clk) disable iff (i_rst)
    src |-> smp_x == ACC_W'(i_thr_data) && smp_v == i_thr_valid) else $error("wrong source");
  a_timeout_err: assert property (@(posedge i_clk) disable iff (i_rst)
    state == rra_pkg::RRA_RUN && !take && tmo_hit && !stop && !start
    |=> state == rra_pkg::RRA_FAIL && irq_stat[rra_pkg::IRQ_TMO]) else $error("timeout missed");
  a_len_floor: assert property (@(posedge i_clk) disable iff (i_rst)
    len != '0 && avg != '0) else $error("zero length or averages");
  a_fast_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    take && too_fast |=> irq_stat[rra_pkg::IRQ_OVR]) else $error("overrun not flagged");
  a_div_ends: assert property (@(posedge i_clk) disable iff (i_rst)
    div_start |=> div_busy [*8]) else $error("divider stopped early");

  c_cyclic_done: cover property (@(posedge i_clk) disable iff (i_rst) take && all_done && !mode);
  c_seq_done: cover property (@(posedge i_clk) disable iff (i_rst) take && all_done && mode);
  c_timeout: cover property (@(posedge i_clk) disable iff (i_rst) state == rra_pkg::RRA_FAIL);
  c_result_read: cover property (@(posedge i_clk) disable iff (i_rst) $fell(div_busy));
endmodule

// ### test/rra_src_model.sv
// Upstream model: weighted integration and state discrimination results
`timescale 1ns/100ps
module rra_src_model (
  input  wire logic                        i_clk,
  output logic                             o_int_valid,
  output logic [rra_pkg::DATA_W-1:0]       o_int_data,
  output logic                             o_thr_valid,
  output logic [rra_pkg::STATE_W-1:0]      o_thr_data
);
  initial begin
    o_int_valid = 1'b0;
    o_thr_valid = 1'b0;
    o_int_data  = '0;
    o_thr_data  = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both units fire together, so the logger's source selector decides
  task automatic send(input logic [rra_pkg::DATA_W-1:0] iv, input logic [rra_pkg::STATE_W-1:0] tv,
                      input int slow);
    @(posedge i_clk);
    o_int_valid <= 1'b1;
    o_thr_valid <= 1'b1;
    o_int_data  <= iv;
    o_thr_data  <= tv;
    @(posedge i_clk);
    o_int_valid <= 1'b0;
    o_thr_valid <= 1'b0;
    // Stale data is inverted so a late sample cannot match by luck
    o_int_data  <= ~iv;
    o_thr_data  <= ~tv;
    repeat (rra_pkg::MIN_GAP_CYC - 2 + slow) @(posedge i_clk);
  endtask
endmodule

// ### test/tb_readout_result_averager.sv
// Self-checking bench for the readout result averager
`timescale 1ns/100ps
module tb_readout_result_averager;
  logic                          i_clk;
  logic                          i_rst;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          int_valid;
  logic [rra_pkg::DATA_W-1:0]    int_data;
  logic                          thr_valid;
  logic [rra_pkg::STATE_W-1:0]   thr_data;
  logic                          irq;
  logic                          running;
  logic [31:0]                   q;
  logic                          e;
  int                            err_count;
  int                            num_checks;
  int                            cyc;

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  // Short idle timeout keeps the timeout scenario brief
  rra_logger #(.TMO_CYC(50)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_int_valid(int_valid), .i_int_data(int_data), .i_thr_valid(thr_valid), .i_thr_data(thr_data),
    .o_irq(irq), .o_running(running)
  );

  rra_src_model src_u (
    .i_clk(i_clk), .o_int_valid(int_valid), .o_int_data(int_data),
    .o_thr_valid(thr_valid), .o_thr_data(thr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic        y;
    apb(1'b0, a, 32'h0, x, y);
    chk(name, exp, x);
  endtask

  task automatic pt_chk(input int idx, input int exp);
    logic [31:0] x;
    logic        y;
    int          n;
    wr(rra_pkg::ADR_RIDX, 32'(idx));
    n = 0;
    do begin
      apb(1'b0, rra_pkg::ADR_STAT, 32'h0, x, y);
      n++;
    end while (x[1] !== 1'b0 && n < 100);
    rdchk("point", rra_pkg::ADR_RDATA, 32'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("idle outputs", 32'h0, {29'h0, irq, running, pready});
    rdchk("ctrl", rra_pkg::ADR_CTRL, 32'h0);
    rdchk("len", rra_pkg::ADR_LEN, 32'h1);
    rdchk("avg", rra_pkg::ADR_AVG, 32'h1);
    rdchk("mask", rra_pkg::ADR_MASK, 32'h0);
    apb(1'b0, 8'h28, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask

  task automatic t_limits;
    wr(rra_pkg::ADR_LEN, 32'h80000);
    rdchk("len max", rra_pkg::ADR_LEN, 32'h80000);
    wr(rra_pkg::ADR_LEN, 32'h80001);
    rdchk("len over", rra_pkg::ADR_LEN, 32'h1);
    wr(rra_pkg::ADR_AVG, 32'h20000);
    rdchk("avg max", rra_pkg::ADR_AVG, 32'h20000);
    wr(rra_pkg::ADR_AVG, 32'h0);
    rdchk("avg zero", rra_pkg::ADR_AVG, 32'h1);
  endtask

  task automatic t_cyclic;
    int r[6] = '{10, -7, 100, 21, -4, -3};
    wr(rra_pkg::ADR_MASK, 32'h1);
    wr(rra_pkg::ADR_LEN, 32'h3);
    wr(rra_pkg::ADR_AVG, 32'h2);
    wr(rra_pkg::ADR_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      src_u.send(24'(r[i]), 4'(i), 0);
      if (i == 4) chk("running early", 32'h1, {31'h0, running});
    end
    repeat (3) @(posedge i_clk);
    chk("running done", 32'h0, {31'h0, running});
    chk("irq done", 32'h1, {31'h0, irq});
    rdchk("acquired", rra_pkg::ADR_ACQ_LO, 32'h6);
    rdchk("irq stat", rra_pkg::ADR_IRQ, 32'h1);
    for (int k = 0; k < 3; k++) pt_chk(k, (r[k] + r[k + 3]) / 2);
    wr(rra_pkg::ADR_IRQ, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask

  task automatic t_seq;
    int t[6] = '{1, 2, 4, 15, 15, 14};
    wr(rra_pkg::ADR_LEN, 32'h2);
    wr(rra_pkg::ADR_AVG, 32'h3);
    wr(rra_pkg::ADR_CTRL, 32'h6);
    wr(rra_pkg::ADR_CTRL, 32'h7);
    for (int i = 0; i < 6; i++) src_u.send(24'(i * 1000 - 2500), 4'(t[i]), 0);
    rdchk("acquired", rra_pkg::ADR_ACQ_LO, 32'h6);
    rdchk("ctrl seq", rra_pkg::ADR_CTRL, 32'h6);
    pt_chk(0, (t[0] + t[1] + t[2]) / 3);
    pt_chk(1, (t[3] + t[4] + t[5]) / 3);
    wr(rra_pkg::ADR_IRQ, 32'h1);
  endtask

  task automatic t_stop;
    wr(rra_pkg::ADR_CTRL, 32'h0);
    wr(rra_pkg::ADR_LEN, 32'h4);
    wr(rra_pkg::ADR_AVG, 32'h1);
    wr(rra_pkg::ADR_CTRL, 32'h1);
    // Second result comes one cycle early to provoke the overrun flag
    src_u.send(24'h5, 4'h1, -1);
    src_u.send(24'h6, 4'h2, 2);
    wr(rra_pkg::ADR_CTRL, 32'h0);
    repeat (2) @(posedge i_clk);
    chk("running stop", 32'h0, {31'h0, running});
    rdchk("acquired stop", rra_pkg::ADR_ACQ_LO, 32'h2);
    rdchk("acquired hi", rra_pkg::ADR_ACQ_HI, 32'h0);
    rdchk("irq stop", rra_pkg::ADR_IRQ, 32'h4);
    wr(rra_pkg::ADR_IRQ, 32'h4);
    rdchk("irq overrun clear", rra_pkg::ADR_IRQ, 32'h0);
    wr(rra_pkg::ADR_CTRL, 32'h1);
    rdchk("acquired restart", rra_pkg::ADR_ACQ_LO, 32'h0);
    wr(rra_pkg::ADR_CTRL, 32'h0);
  endtask

  task automatic t_timeout;
    wr(rra_pkg::ADR_MASK, 32'h0);
    wr(rra_pkg::ADR_CTRL, 32'h1);
    repeat (70) @(posedge i_clk);
    rdchk("status fail", rra_pkg::ADR_STAT, 32'h4);
    rdchk("irq timeout", rra_pkg::ADR_IRQ, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(rra_pkg::ADR_MASK, 32'h2);
    repeat (2) @(posedge i_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(rra_pkg::ADR_IRQ, 32'h2);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(rra_pkg::ADR_CTRL, 32'h0);
    rdchk("status idle", rra_pkg::ADR_STAT, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    i_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_limits();
    t_cyclic();
    t_seq();
    t_stop();
    t_timeout();
    give_verdict();
  end
endmodule
